// *** switch_eval_pkg.sv ***
// package: constants, enums and carrier structs for switching output eval
//
// How it works
// - alarm mode holds output active without measurement
// - level warning drives both outputs below threshold
// - threshold zero to 5000, default 1700
// - timer stage: off, on, off, on/off, pulse
// - jump mode asserts on qualifying value jump
// - jump magnitude must lie within min and max
// - only the difference matters, not absolute distance
// - positive direction: only larger distances detected
// - negative direction: only smaller distances detected
// - both directions default, any sign detected
// - compare against value n cycles earlier
// - off mode drives output low whatever the polarity, no evaluation
package switch_eval_pkg;

  // measured values in 0.01 mm units, signed
  localparam int unsigned VALUE_W    = 32;
  localparam int unsigned LEVEL_W    = 13;
  localparam int unsigned OFFSET_W   = 14;
  localparam int unsigned TIMER_W    = 15;

  // limits and factory defaults
  localparam logic [LEVEL_W-1:0]  LEVEL_MAX      = 13'd5000;
  localparam logic [LEVEL_W-1:0]  LEVEL_DEFAULT  = 13'd1700;
  localparam logic [VALUE_W-1:0]  JUMP_LIMIT_MAX = 32'd214748;
  localparam logic [OFFSET_W-1:0] OFFSET_MIN     = 14'd1;
  localparam logic [OFFSET_W-1:0] OFFSET_MAX     = 14'd10000;
  localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT = 14'd50;
  localparam logic [TIMER_W-1:0]  TIMER_MS_MIN   = 15'd1;
  localparam logic [TIMER_W-1:0]  TIMER_MS_MAX   = 15'd30000;

  // clock rate and one millisecond tick
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned MS_CYCLES   = CLK_HZ / MS_PER_S;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_ALARM,
    MODE_LEVEL_WARN,
    MODE_JUMP
  } out_mode_e;

  typedef enum logic [2:0] {
    TIMER_OFF,
    TIMER_ON_DELAY,
    TIMER_OFF_DELAY,
    TIMER_ON_OFF_DELAY,
    TIMER_PULSE
  } timer_mode_e;

  typedef enum logic [1:0] {
    DIR_POSITIVE,
    DIR_NEGATIVE,
    DIR_BOTH
  } jump_dir_e;

  // one measurement from the core
  typedef struct packed {
    logic                      valid;
    logic signed [VALUE_W-1:0] distance;
    logic        [LEVEL_W-1:0] level;
  } sample_s;

  // configuration of the first switching output
  typedef struct packed {
    out_mode_e                 mode;
    logic                      low_active;
    timer_mode_e               timer_mode;
    logic        [TIMER_W-1:0] timer_ms;
    logic        [LEVEL_W-1:0] level_thresh;
    logic        [VALUE_W-1:0] jump_min;
    logic        [VALUE_W-1:0] jump_max;
    jump_dir_e                 jump_dir;
    logic       [OFFSET_W-1:0] cycle_offset;
  } config_s;

  localparam config_s CONFIG_DEFAULT = '{
    mode:         MODE_OFF,
    low_active:   1'b0,
    timer_mode:   TIMER_OFF,
    timer_ms:     TIMER_MS_MIN,
    level_thresh: LEVEL_DEFAULT,
    jump_min:     '0,
    jump_max:     '0,
    jump_dir:     DIR_BOTH,
    cycle_offset: OFFSET_DEFAULT
  };

  // clamp a value to an upper limit
  function automatic logic [VALUE_W-1:0] clamp_value(
    input logic [VALUE_W-1:0] v,
    input logic [VALUE_W-1:0] hi
  );
    return (v > hi) ? hi : v;
  endfunction

endpackage

// *** switch_timer.sv ***
// timer stage: delays and one-shot pulse on a condition level
`timescale 1ns/1ps
module switch_timer
  import switch_eval_pkg::*;
#(
  parameter int unsigned MS_TICKS = MS_CYCLES
)
(
  // clock, reset, enable
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  input  wire logic               ce_in,
  // settings
  input  wire timer_mode_e        mode_in,
  input  wire logic [TIMER_W-1:0] ms_in,
  // condition in, timed condition out
  input  wire logic               cond_in,
  output logic                    cond_out
);

  // refuse a prescaler that cannot count a millisecond
  if (MS_TICKS < 1)
  begin : g_bad_ticks
    $error("switch_timer: MS_TICKS must be at least one");
  end

  logic [31:0]        tick_q;
  logic [TIMER_W-1:0] ms_q;
  logic               run_q;
  logic               state_q;
  logic               cond_prev_q;
  logic               ms_tick;
  logic               done;
  logic [TIMER_W-1:0] ms_limit;

  assign ms_tick  = run_q && (tick_q == MS_TICKS - 1);
  // clamp setting into its legal range
  assign ms_limit = (ms_in < TIMER_MS_MIN) ? TIMER_MS_MIN :
                    (ms_in > TIMER_MS_MAX) ? TIMER_MS_MAX : ms_in;
  assign done     = ms_tick && (ms_q + 1'b1 >= ms_limit);

  // millisecond prescaler while running
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      tick_q <= '0;
    else if (ce_in)
      tick_q <= (!run_q || ms_tick) ? '0 : tick_q + 32'd1;
  end

  // state, run flag and elapsed ms
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q     <= 1'b0;
      run_q       <= 1'b0;
      ms_q        <= '0;
      cond_prev_q <= 1'b0;
    end
    else if (ce_in)
    begin
      cond_prev_q <= cond_in;
      if (ms_tick)
        ms_q <= ms_q + 1'b1;
      unique case (mode_in)
        TIMER_OFF:
        begin
          state_q <= cond_in;
          run_q   <= 1'b0;
          ms_q    <= '0;
        end
        TIMER_ON_DELAY, TIMER_OFF_DELAY, TIMER_ON_OFF_DELAY:
        begin
          // run while cond differs from output and that edge is delayed
          if ((cond_in != state_q) &&
              ((cond_in  && mode_in != TIMER_OFF_DELAY) ||
               (!cond_in && mode_in != TIMER_ON_DELAY)))
          begin
            run_q <= 1'b1;
            if (done)
            begin
              state_q <= cond_in;
              run_q   <= 1'b0;
              ms_q    <= '0;
            end
          end
          else
          begin
            state_q <= cond_in;
            run_q   <= 1'b0;
            ms_q    <= '0;
          end
        end
        TIMER_PULSE:
        begin
          if (cond_in && !cond_prev_q && !state_q)
          begin
            state_q <= 1'b1;
            run_q   <= 1'b1;
            ms_q    <= '0;
          end
          else if (done)
          begin
            state_q <= 1'b0;
            run_q   <= 1'b0;
            ms_q    <= '0;
          end
        end
        default:
        begin
          state_q <= 1'b0;
          run_q   <= 1'b0;
          ms_q    <= '0;
        end
      endcase
    end
  end

  assign cond_out = state_q;

endmodule

// *** switch_output_eval.sv ***
// first switching output evaluation: alarm, level warning, jump, off
`timescale 1ns/1ps
module switch_output_eval
  import switch_eval_pkg::*;
#(
  parameter int unsigned MAX_OFFSET = OFFSET_MAX,
  parameter int unsigned MS_TICKS   = MS_CYCLES
)
(
  // clock, reset, enable
  input  wire logic    clk_in,
  input  wire logic    rstn_in,
  input  wire logic    ce_in,
  // measurement core, one pulse per measurement cycle
  input  wire logic    sample_stb_in,
  input  wire sample_s sample_in,
  // settings
  input  wire config_s config_in,
  // switching outputs
  output logic         switch_output_one_out,
  output logic         switch_output_two_warn_out
);

  // refuse history depths the ring cannot serve
  if (MAX_OFFSET < 1 || MAX_OFFSET > OFFSET_MAX)
  begin : g_bad_offset
    $error("switch_output_eval: MAX_OFFSET out of range");
  end

  localparam int unsigned AW = $clog2(MAX_OFFSET + 1);

  //////////////////////////////////////////////////////////////////////////////
  // history of past measured values

  logic signed [VALUE_W-1:0] hist_mem [MAX_OFFSET+1];
  logic [AW-1:0]             wr_ptr_q;
  logic [OFFSET_W:0]         filled_q;
  logic [OFFSET_W-1:0]       offset;
  logic [AW-1:0]             rd_ptr;
  logic signed [VALUE_W-1:0] past_value;
  logic                      past_ok;

  // clamp cycle count to 1..MAX_OFFSET
  assign offset = (config_in.cycle_offset < OFFSET_MIN) ? OFFSET_MIN :
                  (config_in.cycle_offset > OFFSET_W'(MAX_OFFSET)) ?
                  OFFSET_W'(MAX_OFFSET) : config_in.cycle_offset;

  // value taken offset cycles earlier
  always_comb
  begin
    logic [AW:0] diff;
    diff = {1'b0, wr_ptr_q} - AW'(offset) + 1'b0;
    if (wr_ptr_q >= AW'(offset))
      rd_ptr = wr_ptr_q - AW'(offset);
    else
      rd_ptr = AW'(diff + (AW+1)'(MAX_OFFSET + 1));
  end

  assign past_value = hist_mem[rd_ptr];
  assign past_ok    = filled_q >= (OFFSET_W+1)'(offset);

  // write valid measurements into the ring, count how many are held
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_ptr_q <= '0;
      filled_q <= '0;
    end
    else if (ce_in && sample_stb_in)
    begin
      if (config_in.mode != MODE_JUMP || !sample_in.valid)
        filled_q <= '0;
      else
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(MAX_OFFSET)) ? '0 : wr_ptr_q + 1'b1;
        if (filled_q < (OFFSET_W+1)'(MAX_OFFSET))
          filled_q <= filled_q + 1'b1;
      end
    end
  end

  // ring storage, no reset needed
  always_ff @(posedge clk_in)
  begin
    if (ce_in && sample_stb_in && sample_in.valid)
      hist_mem[wr_ptr_q] <= sample_in.distance;
  end

  //////////////////////////////////////////////////////////////////////////////
  // jump evaluation

  logic signed [VALUE_W:0] delta;
  logic [VALUE_W:0]        magnitude;
  logic [VALUE_W-1:0]      lim_min;
  logic [VALUE_W-1:0]      lim_max;
  logic                    in_limits;
  logic                    dir_ok;
  logic                    jump_q;

  // signed difference only, absolute distance unused
  assign delta     = $signed({sample_in.distance[VALUE_W-1],
                              sample_in.distance}) -
                     $signed({past_value[VALUE_W-1], past_value});
  assign magnitude = delta[VALUE_W] ? (VALUE_W+1)'(-delta)
                                    : (VALUE_W+1)'(delta);
  assign lim_min   = clamp_value(config_in.jump_min, JUMP_LIMIT_MAX);
  assign lim_max   = clamp_value(config_in.jump_max, JUMP_LIMIT_MAX);
  assign in_limits = (magnitude >= {1'b0, lim_min}) &&
                     (magnitude <= {1'b0, lim_max});

  // direction filter
  always_comb
  begin
    unique case (config_in.jump_dir)
      DIR_POSITIVE: dir_ok = !delta[VALUE_W] && (delta != '0);
      DIR_NEGATIVE: dir_ok = delta[VALUE_W];
      DIR_BOTH:     dir_ok = 1'b1;
      default:      dir_ok = 1'b1;
    endcase
  end

  // jump result held until the next measurement
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      jump_q <= 1'b0;
    else if (ce_in && sample_stb_in)
      jump_q <= (config_in.mode == MODE_JUMP) && sample_in.valid &&
                past_ok && in_limits && dir_ok;
  end

  //////////////////////////////////////////////////////////////////////////////
  // alarm and level warning conditions

  logic               alarm_q;
  logic               low_level_q;
  logic [LEVEL_W-1:0] thresh;

  assign thresh = (config_in.level_thresh > LEVEL_MAX) ? LEVEL_MAX
                                                       : config_in.level_thresh;

  // no measurement possible: hold active until valid again
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      alarm_q <= 1'b0;
    else if (ce_in && sample_stb_in)
      alarm_q <= !sample_in.valid;
  end

  // received level below threshold
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      low_level_q <= 1'b0;
    else if (ce_in && sample_stb_in)
      low_level_q <= sample_in.level < thresh;
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode select, timer, polarity

  logic cond;
  logic timed;

  always_comb
  begin
    unique case (config_in.mode)
      MODE_OFF:        cond = 1'b0;
      MODE_ALARM:      cond = alarm_q;
      MODE_LEVEL_WARN: cond = low_level_q;
      MODE_JUMP:       cond = jump_q;
      default:         cond = 1'b0;
    endcase
  end

  switch_timer #(
    .MS_TICKS (MS_TICKS)
  ) u_timer (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .ce_in    (ce_in),
    .mode_in  ((config_in.mode == MODE_ALARM) ? TIMER_OFF
                                                : config_in.timer_mode),
    .ms_in    (config_in.timer_ms),
    .cond_in  (cond),
    .cond_out (timed)
  );

  // polarity after the timer; off mode drives low regardless of polarity
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      switch_output_one_out <= 1'b0;
    else if (ce_in)
    begin
      if (config_in.mode == MODE_OFF)
        switch_output_one_out <= 1'b0;
      else
        switch_output_one_out <= timed ^ config_in.low_active;
    end
  end

  // warning share for the second output
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      switch_output_two_warn_out <= 1'b0;
    else if (ce_in)
      switch_output_two_warn_out <= (config_in.mode == MODE_LEVEL_WARN) &&
                                    low_level_q;
  end

endmodule

// *** switch_eval_assertions.sv ***
// checker: timing and level relations of the switching outputs
`timescale 1ns/1ps
module switch_eval_assertions
  import switch_eval_pkg::*;
(
  // clock, reset, enable
  input wire logic    clk_in,
  input wire logic    rstn_in,
  input wire logic    ce_in,
  // core and settings
  input wire logic    sample_stb_in,
  input wire sample_s sample_in,
  input wire config_s config_in,
  // outputs
  input wire logic    switch_output_one_out,
  input wire logic    switch_output_two_warn_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic               tk, lo, wr, one, two, pol;
  logic [LEVEL_W-1:0] thr;
  // taken strobe, clamped threshold, low level
  assign tk  = ce_in && sample_stb_in;
  assign thr = (config_in.level_thresh > LEVEL_MAX) ? LEVEL_MAX
             : config_in.level_thresh;
  assign lo  = sample_in.valid && sample_in.level < thr;
  assign wr  = config_in.mode == MODE_LEVEL_WARN;
  assign one = switch_output_one_out;
  assign two = switch_output_two_warn_out;
  assign pol = config_in.low_active;
  ////////////////////////////////////////
  chk_warn_sets: assert property (
    tk && lo && wr |-> ##[1:2] two) else $error("warning not raised");
  chk_warn_clears: assert property (
    tk && sample_in.valid && !lo && wr |-> ##[1:2] !two)
    else $error("warning not cleared");
  chk_warn_polarity: assert property (
    tk && lo && wr && config_in.timer_mode == TIMER_OFF |-> ##4 one != pol)
    else $error("warning level wrong on output one");
  chk_alarm_sets: assert property (
    tk && !sample_in.valid && config_in.mode == MODE_ALARM |-> ##4 one != pol)
    else $error("alarm not active");
  chk_alarm_release: assert property (
    tk && sample_in.valid && config_in.mode == MODE_ALARM |-> ##4 one == pol)
    else $error("alarm not released");
  chk_off_quiet: assert property (
    tk && config_in.mode == MODE_OFF |-> ##4 !one)
    else $error("output one active in off mode");
  chk_on_delay_hold: assert property (
    tk && lo && wr && config_in.timer_mode == TIMER_ON_DELAY &&
    config_in.timer_ms > 15'h1 && one == pol |-> (one == pol) [*4])
    else $error("switch-on delay too short");
  chk_freeze_outputs: assert property (
    !ce_in |=> $stable(one) && $stable(two)) else $error("outputs moved");
  // main scenarios
  cover property (tk && lo && wr ##2 two);
  cover property (config_in.mode == MODE_ALARM && one != pol);
  cover property (config_in.mode == MODE_JUMP && one);
endmodule

// *** control_reader.sv ***
// control system model reading switching output one
`timescale 1ns/1ps
module control_reader
(
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  rstn_in,
  // pin and its logic setting
  input  wire logic  pin_in,
  input  wire logic  low_active_in,
  // active level and count of activations
  output logic       active_out,
  output logic [7:0] rises_out
);
  logic       act_q;
  logic [7:0] rises_q;
  // pin level read through the chosen polarity
  assign active_out = pin_in ^ low_active_in;
  assign rises_out  = rises_q;
  // count activations of the output
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      act_q   <= 1'b0;
      rises_q <= 8'h0;
    end
    else
    begin
      act_q <= active_out;
      if (active_out && !act_q)
        rises_q <= rises_q + 8'h1;
    end
  end
endmodule

// *** switch_output_eval_test.sv ***
// testbench for the first switching output evaluation
`timescale 1ns/1ps
module switch_output_eval_test
  import switch_eval_pkg::*;
;
  logic       clk_in, rstn_in, ce_in, stb, one, two, act;
  logic [7:0] rises;
  sample_s    smp;
  config_s    cfg;
  int         err_count, total_checks;
  // design, shortened counts
  switch_output_eval #(.MAX_OFFSET(8), .MS_TICKS(4)) dut (
    .clk_in, .rstn_in, .ce_in, .sample_stb_in(stb), .sample_in(smp),
    .config_in(cfg), .switch_output_one_out(one),
    .switch_output_two_warn_out(two));
  control_reader ctl (.clk_in, .rstn_in, .pin_in(one),
    .low_active_in(cfg.low_active), .active_out(act), .rises_out(rises));
  ////////////////////////////////////////
  task automatic check(input logic seen, input logic want);
    total_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("[FAIL] %0t ns: saw %b, expected %b", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // one measurement strobe, then w idle cycles
  task automatic send(input logic v, input logic signed [VALUE_W-1:0] d,
                      input logic [LEVEL_W-1:0] l, input int w);
    smp = '{valid: v, distance: d, level: l};
    stb = 1'b1;
    cyc(1);
    stb = 1'b0;
    cyc(w);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_alarm();
    for (int p = 0; p < 2; p++)
    begin
      cfg = CONFIG_DEFAULT;
      cfg.low_active = p[0];
      cfg.mode = MODE_ALARM;
      send(1'b0, 0, 13'h0, 4);
      check(act, 1'b1);
      check(one, ~p[0]);
      send(1'b1, 0, 13'h0, 4);
      check(act, 1'b0);
    end
    $display("alarm test done");
  endtask
  task automatic t_warn();
    logic [LEVEL_W-1:0] th [6] = '{13'h6a4, 13'h6a4, 13'h0, 13'h1388,
                                   13'h1388, 13'h1fff};
    logic [LEVEL_W-1:0] lv [6] = '{13'h6a3, 13'h6a4, 13'h0, 13'h1387,
                                   13'h1388, 13'h1389};
    logic [5:0]         ex = 6'h09;
    for (int i = 0; i < 6; i++)
    begin
      cfg = CONFIG_DEFAULT;
      cfg.mode = MODE_LEVEL_WARN;
      cfg.level_thresh = th[i];
      send(1'b1, 0, lv[i], 4);
      check(two, ex[i]);
      check(act, ex[i]);
    end
    // strobe ignored while the enable is low
    ce_in = 1'b0;
    send(1'b1, 0, 13'h0, 4);
    check(two, 1'b0);
    ce_in = 1'b1;
    send(1'b1, 0, 13'h0, 4);
    check(two, 1'b1);
    $display("level warning test done");
  endtask
  task automatic t_jump();
    jump_dir_e dr [12] = '{DIR_BOTH, DIR_BOTH, DIR_POSITIVE, DIR_POSITIVE,
      DIR_NEGATIVE, DIR_NEGATIVE, DIR_BOTH, DIR_BOTH, DIR_BOTH, DIR_BOTH,
      DIR_BOTH, DIR_BOTH};
    int de [12] = '{100, -100, 100, -100, -100, 100, 300, 40, 200, 50,
                    100, 100};
    logic [11:0] ex = 12'h717;
    int          base;
    for (int i = 0; i < 12; i++)
    begin
      cfg = CONFIG_DEFAULT;
      cfg.low_active = 1'b1;
      send(1'b0, 0, 13'h0, 4);
      check(one, 1'b0);
      cfg = '{MODE_JUMP, 1'b0, TIMER_OFF, 15'h1, 13'h6a4, 32'h32, 32'hc8,
              dr[i], 14'h4};
      base = (i == 10) ? 100000 : 1000;
      // only the value four cycles back lies within the limits
      send(1'b1, base, 13'h0, 1);
      repeat ((i == 11) ? 2 : 3) send(1'b1, base + 1000, 13'h0, 1);
      send(1'b1, base + de[i], 13'h0, 4);
      check(act, ex[i]);
      check(one, ex[i]);
    end
    $display("jump test done");
  endtask
  task automatic t_timer();
    timer_mode_e tm [4] = '{TIMER_ON_DELAY, TIMER_OFF_DELAY,
                            TIMER_ON_OFF_DELAY, TIMER_PULSE};
    logic [3:0]  e0 = 4'ha;
    logic [3:0]  e1 = 4'h7;
    logic [3:0]  e2 = 4'h6;
    logic [7:0]  r0;
    for (int i = 0; i < 4; i++)
    begin
      cfg = CONFIG_DEFAULT;
      cfg.mode = MODE_LEVEL_WARN;
      cfg.timer_mode = tm[i];
      cfg.timer_ms = 15'h2;
      cyc(2);
      r0 = rises;
      send(1'b1, 0, 13'h0, 4);
      check(act, e0[i]);
      cyc(16);
      check(act, e1[i]);
      check(rises == r0 + 8'h1, 1'b1);
      send(1'b1, 0, 13'h1fff, 4);
      check(act, e2[i]);
      cyc(16);
      check(act, 1'b0);
    end
    $display("timer test done");
  endtask
  ////////////////////////////////////////
  // clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // watchdog
  initial
  begin
    #50us;
    err_count++;
    close_out();
  end
  // main sequence
  initial
  begin
    rstn_in = 1'b0;
    ce_in = 1'b1;
    stb = 1'b0;
    smp = '0;
    cfg = CONFIG_DEFAULT;
    err_count = 0;
    total_checks = 0;
    cyc(2);
    rstn_in = 1'b1;
    cyc(1);
    t_alarm();
    t_warn();
    t_jump();
    t_timer();
    close_out();
  end
endmodule
bind switch_output_eval switch_eval_assertions chk (.clk_in, .rstn_in,
  .ce_in, .sample_stb_in, .sample_in, .config_in, .switch_output_one_out,
  .switch_output_two_warn_out);
